// ---- shared/ptp_pkg.sv ----
// Constants, register map and types for the point-table positioning controller.
// Assumes a single 25 MHz clock domain and a plain strobe register port.
package ptp_pkg;

  // ******************************************************************
  // Register map (byte addresses, one 32-bit word each)
  // ******************************************************************
  localparam logic [9:0] ADDR_HOME_OFS  = 10'h000;
  localparam logic [9:0] ADDR_LIM_PLUS  = 10'h004;
  localparam logic [9:0] ADDR_LIM_MINUS = 10'h008;
  localparam logic [9:0] ADDR_ROT_TRAV  = 10'h00C;
  localparam logic [9:0] ADDR_CTRL      = 10'h010;
  localparam logic [9:0] ADDR_CMD       = 10'h014;
  localparam logic [9:0] ADDR_STATUS    = 10'h018;
  localparam logic [9:0] ADDR_IRQ_STAT  = 10'h01C;
  localparam logic [9:0] ADDR_IRQ_MASK  = 10'h020;
  localparam logic [9:0] ADDR_CMD_POS   = 10'h024;
  localparam logic [9:0] ADDR_CUR_STEP  = 10'h028;
  localparam logic [9:0] ADDR_STEP_BASE = 10'h100;
  localparam logic [9:0] ADDR_STEP_END  = 10'h2DF;

  // ******************************************************************
  // Step table layout
  // ******************************************************************
  localparam int            STEP_COUNT   = 60;
  localparam logic [5:0]    STEP_FIRST   = 6'h01;
  localparam logic [5:0]    STEP_LAST    = 6'h3C;
  localparam logic [31:0]   STEP_VAL_DEF = 32'h0000_0000;
  // Attribute word: [1:0] mode, [5:2] speed, [7:6] accel, [9:8] decel, [10] block.
  localparam int            ATTR_W       = 11;
  localparam int            F_SPD_LO     = 2;
  localparam int            F_ACC_LO     = 6;
  localparam int            F_DEC_LO     = 8;
  localparam int            F_BLK        = 10;
  localparam logic [10:0]   ATTR_DEF     = 11'h001;

  typedef enum logic [1:0] {
    MODE_ABS    = 2'b00,
    MODE_INC    = 2'b01,
    MODE_ROT    = 2'b10,
    MODE_DWELL  = 2'b11
  } ptp_mode_e;

  // ******************************************************************
  // Limits and error codes
  // ******************************************************************
  localparam logic signed [31:0] HOME_OFS_MIN = 32'sh8000_0001;
  localparam logic [31:0]  ROT_MIN     = 32'h0000_0002;
  localparam logic [31:0]  ROT_MAX     = 32'h4000_0000;
  localparam logic [7:0]   ERR_TRAVEL  = 8'h48;
  localparam logic [7:0]   ERR_UNDEF   = 8'h45;
  localparam logic [31:0]  ZERO32      = 32'h0000_0000;

  // Interrupt status and mask bits.
  localparam int IRQ_W     = 4;
  localparam int EV_TRAVEL = 0;
  localparam int EV_UNDEF  = 1;
  localparam int EV_DONE   = 2;
  localparam int EV_HOMED  = 3;

  // ******************************************************************
  // Timing
  // ******************************************************************
  localparam int CLK_HZ      = 25_000_000;
  localparam int DWELL_MS    = 10;
  localparam int DWELL_TICKS = CLK_HZ / 1000 * DWELL_MS;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_MOVE  = 2'b01,
    ST_DWELL = 2'b10,
    ST_ERROR = 2'b11
  } ptp_state_e;

endpackage : ptp_pkg

// ---- rtl/ptp_tick_gen.sv ----
// Divider that produces one pulse per dwell time unit.
// Assumes the system clock and a synchronous active-low reset.
`timescale 1ns/1ns
module ptp_tick_gen
  import ptp_pkg::*;
#(
  parameter int TICKS = DWELL_TICKS
) (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic rstn,
  input  wire logic clkEn,
  // Control
  input  wire logic run,
  output logic      tick
);

  logic [31:0] cnt_q;
  wire         wrapHit = (cnt_q == 32'(TICKS - 1));

  // Counter restarts whenever the dwell is not running so each wait is whole units.
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      cnt_q <= ZERO32;
      tick  <= 1'b0;
    end else if (clkEn) begin
      tick  <= run && wrapHit;
      cnt_q <= (!run || wrapHit) ? ZERO32 : cnt_q + 32'h0000_0001;
    end
  end

endmodule : ptp_tick_gen

// ---- rtl/ptp_ctrl.sv ----
// Point-table positioning controller: settings, step table, travel checks.
// Assumes a host that writes the step table and starts steps over the register port,
// and a motion profile outside that reports command position steps via posStep.
//
// Summary of operation
// - After homing, the command position is loaded with the signed home offset, default 0.
// - A zero plus-direction limit disables the plus travel error.
// - In a move after homing, command position above a nonzero plus limit raises error 72.
// - A zero minus-direction limit disables the minus travel error.
// - In a move after homing, command position below a nonzero minus limit raises error 72.
// - Travel checks are off while not homed or while wrap acceptance is set.
// - Travel checks apply only while an operation is running, never when stopped.
// - Rotary steps use the per-rotation travel, valid from 2 to 1073741824.
// - An out-of-range per-rotation travel raises error 69 when a rotary step is started by command.
// - Steps 01H to 3CH each pick absolute, incremental (default), rotary or dwell mode.
// - Each step holds a signed 32-bit value, default 0: target pulses or dwell in 10 ms.
// - Each step selects one of sixteen speed entries, first by default.
// - Each step selects one of four accel and four decel entries, first by default.
// - Each step is single (default) or block, which chains into the next step.
`timescale 1ns/1ns
module ptp_ctrl
  import ptp_pkg::*;
(
  // Clock, reset and enable
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  input  wire logic        clkEn,
  // Register port
  input  wire logic [9:0]  regAddr,
  input  wire logic [31:0] regWdata,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic      [31:0] regRdata,
  // Motion side
  input  wire logic        homeDone,
  input  wire logic        jogActive,
  input  wire logic        posStepValid,
  input  wire logic signed [31:0] posStep,
  input  wire logic        moveDone,
  output logic signed [31:0] cmdPos,
  output logic signed [31:0] targetPos,
  output logic      [3:0]  speedSelectIndex,
  output logic      [1:0]  accelSelectIndex,
  output logic      [1:0]  decelSelectIndex,
  output logic             moveStart,
  output logic      [7:0]  errCode,
  output logic             irq
);

  // ******************************************************************
  // Storage
  // ******************************************************************
  logic signed [31:0] homeOfs_q, limPlus_q, limMinus_q;
  logic        [31:0] rotTrav_q;
  logic               wrapAcceptSetting_q;
  logic signed [31:0] stepVal_q [STEP_COUNT];
  logic [ATTR_W-1:0]  stepAttr_q [STEP_COUNT];
  logic [IRQ_W-1:0]   irqStat_q, irqMask_q;
  logic [5:0]         curStep_q;
  logic               homed_q, homeDonePrev_q;
  logic signed [31:0] dwellLeft_q;
  ptp_state_e         state_q;

  // ******************************************************************
  // Address decode
  // ******************************************************************
  wire        inTable  = (regAddr >= ADDR_STEP_BASE) && (regAddr <= ADDR_STEP_END);
  wire [9:0]  tblOfs   = regAddr - ADDR_STEP_BASE;
  wire [5:0]  tblIdx   = tblOfs[8:3];     // Two words per step: value, attributes.
  wire        tblAttr  = tblOfs[2];
  wire        wrTblVal = regWr && inTable && !tblAttr;
  wire        wrTblAtr = regWr && inTable && tblAttr;
  wire        wrCmd    = regWr && (regAddr == ADDR_CMD);
  wire [5:0]  cmdStep  = regWdata[5:0];
  wire        cmdOk    = (cmdStep >= STEP_FIRST) && (cmdStep <= STEP_LAST);

  // ******************************************************************
  // Step fields of the running step
  // ******************************************************************
  wire [5:0]          runIdx   = curStep_q - STEP_FIRST;
  wire [ATTR_W-1:0]   runAttr  = stepAttr_q[runIdx];
  wire signed [31:0]  runVal   = stepVal_q[runIdx];
  wire [1:0]          runMode  = runAttr[1:0];
  wire                runBlock = runAttr[F_BLK];
  wire                lastStep = (curStep_q == STEP_LAST);

  wire cmdRot = stepAttr_q[cmdStep - STEP_FIRST][1:0] == MODE_ROT;  // Rotary steps only.
  wire rotBad = cmdRot && ((rotTrav_q < ROT_MIN) || (rotTrav_q > ROT_MAX));

  // ******************************************************************
  // Travel checks
  // ******************************************************************
  wire checkOn  = homed_q && !wrapAcceptSetting_q &&
                  ((state_q == ST_MOVE) || jogActive);
  wire overPlus = (limPlus_q != ZERO32) && (cmdPos > limPlus_q);
  wire undMinus = (limMinus_q != ZERO32) && (cmdPos < limMinus_q);
  wire travErr  = checkOn && (overPlus || undMinus);

  // Position arithmetic: rotary steps fold back into one rotation.
  wire signed [31:0] rotS   = $signed(rotTrav_q);
  wire signed [31:0] rawPos = cmdPos + posStep;
  wire signed [31:0] wrapHi = rawPos - rotS;
  wire signed [31:0] wrapLo = rawPos + rotS;
  wire               isRot  = (runMode == MODE_ROT) && (state_q == ST_MOVE);
  wire signed [31:0] nxtPos = !isRot          ? rawPos :
                              (rawPos >= rotS) ? wrapHi :
                              (rawPos < 0)     ? wrapLo : rawPos;

  // Target of a new step.
  function automatic logic signed [31:0] stepTarget(input logic [1:0] m,
                                                    input logic signed [31:0] v,
                                                    input logic signed [31:0] p);
    stepTarget = (m == MODE_INC) ? p + v : v;
  endfunction : stepTarget

  // ******************************************************************
  // Dwell timer
  // ******************************************************************
  logic dwellTick;
  ptp_tick_gen #(
    .TICKS (DWELL_TICKS)
  ) u_tick (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .clkEn   (clkEn),
    .run     (state_q == ST_DWELL),
    .tick    (dwellTick)
  );

  // ******************************************************************
  // Events
  // ******************************************************************
  wire startReq  = wrCmd && cmdOk && (state_q == ST_IDLE);
  wire stepEnd   = ((state_q == ST_MOVE) && moveDone) ||
                   ((state_q == ST_DWELL) && dwellTick && (dwellLeft_q <= 1));
  wire chainNext = stepEnd && runBlock && !lastStep;
  wire homeRise  = homeDone && !homeDonePrev_q;
  wire [IRQ_W-1:0] events = {homeRise, stepEnd && !chainNext,
                             startReq && rotBad, travErr};
  wire [IRQ_W-1:0] irqClr = (regWr && (regAddr == ADDR_IRQ_STAT)) ?
                            regWdata[IRQ_W-1:0] : {IRQ_W{1'b0}};

  // ******************************************************************
  // Read mux
  // ******************************************************************
  wire [31:0] rdTbl = tblAttr ? {21'h000000, stepAttr_q[tblIdx]} : stepVal_q[tblIdx];
  wire [31:0] rdMux =
    (regAddr == ADDR_HOME_OFS)  ? homeOfs_q :
    (regAddr == ADDR_LIM_PLUS)  ? limPlus_q :
    (regAddr == ADDR_LIM_MINUS) ? limMinus_q :
    (regAddr == ADDR_ROT_TRAV)  ? rotTrav_q :
    (regAddr == ADDR_CTRL)      ? {31'h00000000, wrapAcceptSetting_q} :
    (regAddr == ADDR_STATUS)    ? {21'h000000, errCode, homed_q, state_q} :
    (regAddr == ADDR_IRQ_STAT)  ? {28'h0000000, irqStat_q} :
    (regAddr == ADDR_IRQ_MASK)  ? {28'h0000000, irqMask_q} :
    (regAddr == ADDR_CMD_POS)   ? cmdPos :
    (regAddr == ADDR_CUR_STEP)  ? {26'h0000000, curStep_q} :
    inTable                     ? rdTbl : ZERO32;

  // ******************************************************************
  // Settings registers
  // ******************************************************************
  // Home offset bottom value is clamped so the symmetric range holds.
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      homeOfs_q           <= ZERO32;
      limPlus_q           <= ZERO32;
      limMinus_q          <= ZERO32;
      rotTrav_q           <= ZERO32;
      wrapAcceptSetting_q <= 1'b0;
      irqMask_q           <= {IRQ_W{1'b0}};
    end else if (clkEn && regWr) begin
      if (regAddr == ADDR_HOME_OFS) begin
        homeOfs_q <= ($signed(regWdata) < HOME_OFS_MIN) ? HOME_OFS_MIN : regWdata;
      end else if (regAddr == ADDR_LIM_PLUS) begin
        limPlus_q <= regWdata[31] ? ZERO32 : regWdata;
      end else if (regAddr == ADDR_LIM_MINUS) begin
        limMinus_q <= (regWdata[31] || regWdata == ZERO32) ? regWdata : ZERO32;
      end else if (regAddr == ADDR_ROT_TRAV) begin
        rotTrav_q <= {1'b0, regWdata[30:0]};
      end else if (regAddr == ADDR_CTRL) begin
        wrapAcceptSetting_q <= regWdata[0];
      end else if (regAddr == ADDR_IRQ_MASK) begin
        irqMask_q <= regWdata[IRQ_W-1:0];
      end
    end
  end

  // ******************************************************************
  // Step table
  // ******************************************************************
  // One entry per step; defaults give incremental, first speed, accel and decel, single.
  genvar gi;
  generate
    for (gi = 0; gi < STEP_COUNT; gi++) begin : g_step
      always_ff @(posedge clk_sys) begin
        if (!rstn) begin
          stepVal_q[gi]  <= STEP_VAL_DEF;
          stepAttr_q[gi] <= ATTR_DEF;
        end else if (clkEn && tblIdx == 6'(gi)) begin
          if (wrTblVal) begin
            stepVal_q[gi] <= regWdata;
          end
          if (wrTblAtr) begin
            stepAttr_q[gi] <= regWdata[ATTR_W-1:0];
          end
        end
      end
    end
  endgenerate

  // ******************************************************************
  // Sequencer
  // ******************************************************************
  // A rotary setting error parks the block in ERROR until the host writes the command register.
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      state_q     <= ST_IDLE;
      curStep_q   <= STEP_FIRST;
      dwellLeft_q <= ZERO32;
      moveStart   <= 1'b0;
    end else if (clkEn) begin
      moveStart <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (startReq && rotBad) begin
            state_q <= ST_ERROR;
          end else if (startReq) begin
            curStep_q <= cmdStep;
            state_q   <= ST_MOVE;
            moveStart <= 1'b1;
          end
        end
        ST_MOVE, ST_DWELL: begin
          if (travErr) begin
            state_q <= ST_ERROR;
          end else if (state_q == ST_DWELL && dwellTick) begin
            dwellLeft_q <= dwellLeft_q - 32'sh0000_0001;
          end
          if (!travErr && chainNext) begin
            curStep_q <= curStep_q + STEP_FIRST;
            state_q   <= ST_MOVE;
            moveStart <= 1'b1;
          end else if (!travErr && stepEnd) begin
            state_q <= ST_IDLE;
          end else if (!travErr && state_q == ST_MOVE && moveStart &&
                       runMode == MODE_DWELL) begin
            dwellLeft_q <= runVal;
            state_q     <= (runVal > 0) ? ST_DWELL : ST_IDLE;
          end
        end
        ST_ERROR: begin
          if (wrCmd) begin
            state_q <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // ******************************************************************
  // Position, homing, error code, outputs
  // ******************************************************************
  // Homing sets the coordinate once, on the rising edge of homeDone.
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      cmdPos           <= ZERO32;
      targetPos        <= ZERO32;
      speedSelectIndex <= 4'h0;
      accelSelectIndex <= 2'h0;
      decelSelectIndex <= 2'h0;
      homed_q          <= 1'b0;
      homeDonePrev_q   <= 1'b0;
      errCode          <= 8'h00;
      irqStat_q        <= {IRQ_W{1'b0}};
      irq              <= 1'b0;
    end else if (clkEn) begin
      homeDonePrev_q <= homeDone;
      homed_q        <= homeDone;
      if (homeRise) begin
        cmdPos <= homeOfs_q;
      end else if (posStepValid) begin
        cmdPos <= nxtPos;
      end
      if (moveStart) begin
        targetPos        <= stepTarget(runMode, runVal, cmdPos);
        speedSelectIndex <= runAttr[F_SPD_LO +: 4];
        accelSelectIndex <= runAttr[F_ACC_LO +: 2];
        decelSelectIndex <= runAttr[F_DEC_LO +: 2];
      end
      if (travErr) begin
        errCode <= ERR_TRAVEL;
      end else if (startReq && rotBad) begin
        errCode <= ERR_UNDEF;
      end else if (startReq) begin
        errCode <= 8'h00;
      end
      irqStat_q <= (irqStat_q & ~irqClr) | events;
      irq       <= |(((irqStat_q & ~irqClr) | events) & irqMask_q);
    end
  end

  // Read data stands for exactly the cycle after the strobe.
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      regRdata <= ZERO32;
    end else if (clkEn) begin
      regRdata <= regRd ? rdMux : ZERO32;
    end
  end

endmodule : ptp_ctrl

// ---- verification/ptp_ctrl_chk.sv ----
// Port checker for the point-table positioning controller.
// Assumes binding to ptp_ctrl with clkEn held high.
`timescale 1ns/1ns
module ptp_ctrl_chk
  import ptp_pkg::*;
(
  // Clock and reset
  input wire logic               clk_sys,
  input wire logic               rstn,
  // Register port
  input wire logic        [9:0]  regAddr,
  input wire logic        [31:0] regWdata,
  input wire logic               regWr,
  input wire logic               regRd,
  input wire logic        [31:0] regRdata,
  // Motion side
  input wire logic               homeDone,
  input wire logic signed [31:0] cmdPos,
  input wire logic               moveStart,
  input wire logic        [7:0]  errCode
);
  // ****************************************************************
  // Shadow settings
  // ****************************************************************
  // Only the facts that decide an error and the home offset are kept, so the shadow stays small.
  logic        plusOnQ, minusOnQ, wrapQ, rotBadQ;
  logic [31:0] ofsQ;
  wire  [31:0] rotW   = {1'b0, regWdata[30:0]};
  wire         wrOfs  = regWr && (regAddr == ADDR_HOME_OFS);
  wire         wrPlus = regWr && (regAddr == ADDR_LIM_PLUS);
  wire         wrMin  = regWr && (regAddr == ADDR_LIM_MINUS);
  wire         wrRot  = regWr && (regAddr == ADDR_ROT_TRAV);
  wire         wrCtrl = regWr && (regAddr == ADDR_CTRL);
  wire         travW  = errCode == ERR_TRAVEL;
  wire         undefW = errCode == ERR_UNDEF;
  // A zero rotation travel is out of range, hence the bad reset value.
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      {plusOnQ, minusOnQ, wrapQ, rotBadQ} <= 4'h1;
      ofsQ <= ZERO32;
    end else begin
      if (wrOfs) ofsQ <= (regWdata == 32'h8000_0000) ? HOME_OFS_MIN : regWdata;
      if (wrPlus) plusOnQ <= (regWdata != ZERO32) && !regWdata[31];
      if (wrMin) minusOnQ <= (regWdata != ZERO32) && regWdata[31];
      if (wrRot) rotBadQ <= (rotW < ROT_MIN) || (rotW > ROT_MAX);
      if (wrCtrl) wrapQ <= regWdata[0];
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  a_rdata_idle: assert property (!$past(regRd) |-> regRdata == ZERO32)
    else $error("read data not zero outside its slot");
  a_err_legal: assert property (travW || undefW || errCode == 8'h00)
    else $error("unknown error code");
  a_trav_homed: assert property ($rose(travW) |-> $past(homeDone, 2))
    else $error("travel error before homing");
  a_trav_wrap: assert property ($rose(travW) |-> !$past(wrapQ))
    else $error("travel error with wrap accepted");
  a_trav_limit: assert property ($rose(travW) |-> $past(plusOnQ) || $past(minusOnQ))
    else $error("travel error with both limits zero");
  a_undef_rot: assert property ($rose(undefW) |-> $past(rotBadQ))
    else $error("undefined data error with valid rotation travel");
  a_home_load: assert property ($rose(homeDone) |-> ##[1:3] cmdPos == ofsQ)
    else $error("home offset not loaded");
  a_start_pulse: assert property (moveStart |=> !moveStart)
    else $error("step start longer than one cycle");
endmodule : ptp_ctrl_chk

bind ptp_ctrl ptp_ctrl_chk ptp_ctrl_chk_i (.clk_sys(clk_sys), .rstn(rstn),
  .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
  .regRdata(regRdata), .homeDone(homeDone), .cmdPos(cmdPos),
  .moveStart(moveStart), .errCode(errCode));

// ---- verification/ptp_motion_model.sv ----
// Behavioural motion profile facing the controller's motion ports.
// Assumes targetPos is settled within three cycles of moveStart.
`timescale 1ns/1ns
module ptp_motion_model
  import ptp_pkg::*;
(
  // Clock and reset
  input  wire logic               clk_sys,
  input  wire logic               rstn,
  // Controller side
  input  wire logic               moveStart,
  input  wire logic               jogActive,
  input  wire logic               slow,
  input  wire logic signed [31:0] cmdPos,
  input  wire logic signed [31:0] targetPos,
  output logic                    posStepValid,
  output logic signed      [31:0] posStep,
  output logic                    moveDone
);
  // Remaining distance, cut to steps of at most 100 pulses.
  logic signed [31:0] diffW, stepW;
  logic               busyQ;
  logic        [1:0]  waitQ;
  assign diffW = targetPos - cmdPos;
  assign stepW = (diffW > 100) ? 32'sh0000_0064 : (diffW < -100) ? 32'shFFFF_FF9C : diffW;
  // An idle step word is inverted each cycle so a stale value never reads as data.
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      {busyQ, posStepValid, moveDone} <= 3'h0;
      waitQ <= 2'h0;
      posStep <= 32'sh0000_0000;
    end else begin
      posStepValid <= jogActive;
      posStep <= jogActive ? 32'sh0000_0064 : ~posStep;
      moveDone <= 1'b0;
      if (moveStart) begin
        busyQ <= 1'b1;
        waitQ <= 2'h3;
      end else if (busyQ && waitQ != 2'h0) begin
        waitQ <= waitQ - 2'h1;
      end else if (busyQ && !posStepValid) begin
        posStepValid <= diffW != 0;
        posStep <= stepW;
        moveDone <= diffW == 0;
        busyQ <= diffW != 0;
        waitQ <= slow ? 2'h3 : 2'h0;
      end
    end
  end
endmodule : ptp_motion_model

// ---- verification/ptp_ctrl_tb.sv ----
// Self-checking bench for the point-table positioning controller.
// Assumes the motion model answers steps and jog on the motion ports.
`timescale 1ns/1ns
module ptp_ctrl_tb import ptp_pkg::*; ;
  logic               clk_sys, rstn, clkEn, regWr, regRd, homeDone, jogActive, slow;
  logic        [9:0]  regAddr;
  logic        [31:0] regWdata, regRdata, rdv;
  logic               posStepValid, moveDone, moveStart, irq;
  logic signed [31:0] posStep, cmdPos, targetPos;
  logic        [3:0]  speedSelectIndex;
  logic        [1:0]  accelSelectIndex, decelSelectIndex;
  logic        [7:0]  errCode;
  int                 err_count, check_count, cycles, starts;
  ptp_ctrl ptp_ctrl_i (.clk_sys(clk_sys), .rstn(rstn), .clkEn(clkEn), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .homeDone(homeDone), .jogActive(jogActive), .posStepValid(posStepValid),
    .posStep(posStep), .moveDone(moveDone), .cmdPos(cmdPos), .targetPos(targetPos),
    .speedSelectIndex(speedSelectIndex), .accelSelectIndex(accelSelectIndex),
    .decelSelectIndex(decelSelectIndex), .moveStart(moveStart), .errCode(errCode),
    .irq(irq));
  ptp_motion_model ptp_motion_model_i (.clk_sys(clk_sys), .rstn(rstn),
    .moveStart(moveStart), .jogActive(jogActive), .slow(slow), .cmdPos(cmdPos),
    .targetPos(targetPos), .posStepValid(posStepValid), .posStep(posStep),
    .moveDone(moveDone));
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  // Cycle ceiling well above the longest scenario; also counts step starts.
  always @(posedge clk_sys) begin
    cycles++;
    if (moveStart === 1'b1) starts++;
    if (cycles == 30000) begin
      err_count++;
      wrap_up();
    end
  end
  // ****************************************************************
  // Bus and check tasks
  // ****************************************************************
  task automatic wrap_up();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : wrap_up
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clk_sys);
    regWr <= 1'b0;
  endtask : wr
  // Read data are taken in the one cycle where they stand.
  task automatic rd(input logic [9:0] a);
    @(posedge clk_sys);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk_sys);
    regRd <= 1'b0;
    @(negedge clk_sys);
    rdv = regRdata;
  endtask : rd
  task automatic rst();
    @(posedge clk_sys);
    rstn <= 1'b0;
    repeat (6) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (3) @(posedge clk_sys);
  endtask : rst
  task automatic jog(input int n);
    @(posedge clk_sys);
    jogActive <= 1'b1;
    repeat (n) @(posedge clk_sys);
    jogActive <= 1'b0;
    repeat (3) @(posedge clk_sys);
  endtask : jog
  task automatic step(input int n, input logic [31:0] v, input logic [31:0] at);
    wr(ADDR_STEP_BASE + 10'((n - 1) * 8), v);
    wr(ADDR_STEP_BASE + 10'((n - 1) * 8 + 4), at);
  endtask : step
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_defaults();
    rd(ADDR_HOME_OFS); chk("homeOfs", rdv, ZERO32);
    rd(ADDR_STEP_BASE); chk("stepVal", rdv, STEP_VAL_DEF);
    rd(ADDR_STEP_BASE + 10'h004); chk("attr1", rdv, 32'(ATTR_DEF));
    rd(ADDR_STEP_END - 10'h003); chk("attr60", rdv, 32'(ATTR_DEF));
    rd(10'h3FC); chk("unmapped", rdv, ZERO32);
    wr(ADDR_HOME_OFS, 32'h8000_0000);
    rd(ADDR_HOME_OFS); chk("ofsClamp", rdv, HOME_OFS_MIN);
  endtask : t_defaults
  task automatic t_home();
    wr(ADDR_LIM_PLUS, 32'h0000_01F4);
    jog(10);
    chk("errUnhomed", errCode, 8'h00);
    wr(ADDR_HOME_OFS, 32'h0000_03E8);
    homeDone <= 1'b1;
    repeat (5) @(posedge clk_sys);
    chk("homePos", cmdPos, 32'h0000_03E8);
    chk("errStopped", errCode, 8'h00);
    chk("irqMasked", irq, 1'b0);
    wr(ADDR_IRQ_MASK, 32'h0000_0008);
    repeat (2) @(posedge clk_sys);
    chk("irqHomed", irq, 1'b1);
    rd(ADDR_IRQ_STAT); chk("statHomed", rdv[EV_HOMED], 1'b1);
    wr(ADDR_IRQ_STAT, 32'h0000_0008);
    repeat (2) @(posedge clk_sys);
    chk("irqClear", irq, 1'b0);
  endtask : t_home
  task automatic t_wrap_jog();
    wr(ADDR_CTRL, 32'h0000_0001);
    jog(5);
    chk("errWrap", errCode, 8'h00);
    wr(ADDR_CTRL, 32'h0000_0000);
    repeat (3) @(posedge clk_sys);
    chk("errIdle", errCode, 8'h00);
    wr(ADDR_IRQ_MASK, 32'h0000_0001);
    jog(3);
    chk("errPlus", errCode, ERR_TRAVEL);
    chk("irqTravel", irq, 1'b1);
    rd(ADDR_IRQ_STAT); chk("statTravel", rdv[EV_TRAVEL], 1'b1);
  endtask : t_wrap_jog
  task automatic t_minus();
    rst();
    wr(ADDR_LIM_MINUS, 32'hFFFF_FED4);
    jog(10);
    chk("errPlusOff", errCode, 8'h00);
    step(1, 32'hFFFF_F830, 32'h0000_0395);
    wr(ADDR_CMD, 32'h0000_0001);
    repeat (3) @(posedge clk_sys);
    chk("target", targetPos, 32'hFFFF_FC18);
    chk("speed", speedSelectIndex, 4'h5);
    chk("accel", accelSelectIndex, 2'h2);
    chk("decel", decelSelectIndex, 2'h3);
    for (int i = 0; i < 300 && errCode === 8'h00; i++) @(posedge clk_sys);
    chk("errMinus", errCode, ERR_TRAVEL);
  endtask : t_minus
  task automatic t_rotary();
    logic [31:0] rots[4] = '{32'h0000_0001, 32'h4000_0001, ROT_MAX, 32'h0000_03E8};
    logic [7:0]  errs[4] = '{ERR_UNDEF, ERR_UNDEF, 8'h00, 8'h00};
    for (int i = 0; i < 4; i++) begin
      rst();
      wr(ADDR_ROT_TRAV, rots[i]);
      step(2, 32'h0000_05DC, {30'h0, MODE_ROT});
      wr(ADDR_CMD, 32'h0000_0002);
      repeat (4) @(posedge clk_sys);
      chk("errRot", errCode, errs[i]);
    end
    repeat (40) begin
      @(negedge clk_sys);
      chk("rotRange", 32'(cmdPos >= 0 && cmdPos < 1000), 32'h0000_0001);
    end
  endtask : t_rotary
  task automatic t_block();
    rst();
    slow <= 1'b1;
    starts = 0;
    wr(ADDR_CMD, 32'h0000_003D);
    step(3, 32'h0000_00C8, 32'h0000_0401);
    step(4, 32'h0000_01F4, 32'h0000_0000);
    wr(ADDR_CMD, 32'h0000_0003);
    for (int i = 0; i < 600 && cmdPos !== 32'h0000_01F4; i++) @(posedge clk_sys);
    repeat (20) @(posedge clk_sys);
    chk("starts", starts, 32'h0000_0002);
    chk("absPos", cmdPos, 32'h0000_01F4);
  endtask : t_block
  initial begin
    {rstn, clkEn, regWr, regRd, homeDone, jogActive, slow} = 7'h20;
    regAddr = 10'h000;
    regWdata = 32'h0000_0000;
    rst();
    t_defaults();
    t_home();
    t_wrap_jog();
    t_minus();
    t_rotary();
    t_block();
    wrap_up();
  end
endmodule : ptp_ctrl_tb
